// ### rig_drive.sv
// drive end: adjusting command interpreter holding rigidity and inertia
`timescale 1ns/1ns
module rig_drive
    import rig_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    rig_if.drive             link,
    input  wire logic        autotune_en_i,
    input  wire logic [1:0]  param_sel_i,
    input  wire logic        param_wr_i,
    input  wire logic [15:0] param_data_i,
    output logic [15:0]      position_loop_gain_param_o,
    output logic [15:0]      speed_loop_gain_param_o,
    output logic [15:0]      speed_integral_time_param_o,
    output logic [15:0]      torque_filter_time_param_o,
    output logic [15:0]      inertia_ratio_param_o,
    output logic             applying_o
);
    // ---------------------------------------------------------------
    // level table
    // ---------------------------------------------------------------
    function automatic gains_t table_lookup(input logic [15:0] lvl);
        gains_t g;
        g = '0;
        case (lvl)
            16'h0001: g = '{16'd15,  16'd15,  16'd6000, 16'd250};
            16'h0002: g = '{16'd20,  16'd20,  16'd4500, 16'd200};
            16'h0003: g = '{16'd30,  16'd30,  16'd3000, 16'd130};
            16'h0004: g = '{16'd40,  16'd40,  16'd2000, 16'd100};
            16'h0005: g = '{16'd60,  16'd60,  16'd1500, 16'd70};
            16'h0006: g = '{16'd85,  16'd85,  16'd1000, 16'd50};
            16'h0007: g = '{16'd120, 16'd120, 16'd800,  16'd30};
            16'h0008: g = '{16'd160, 16'd160, 16'd600,  16'd20};
            16'h0009: g = '{16'd200, 16'd200, 16'd500,  16'd15};
            16'h000A: g = '{16'd250, 16'd250, 16'd400,  16'd10};
            default:  g = '{16'd40,  16'd40,  16'd2000, 16'd100};
        endcase
        return g;
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [15:0] level;
        logic [15:0] inertia;
        gains_t      target;
        logic [3:0]  override;
        logic [23:0] apply_cnt;
        logic        applying;
        logic        rsp_valid;
        logic [7:0]  answer;
        logic [15:0] rsp_addr;
        logic [15:0] rsp_data;
        logic [15:0] status;
    } drive_state_t;

    drive_state_t s_r;
    drive_state_t s_nxt;

    localparam logic [23:0] APPLY_CNT = 24'(APPLY_CYCLES);

    logic is_adj;
    logic [15:0] wdata;
    assign is_adj = link.cmd_valid && link.cmd_byte1 == ADJ_BYTE1
                    && link.cmd_byte2 == ADJ_BYTE2;
    assign wdata  = link.setting_reference_data;

    // next-state logic
    always_comb begin
        gains_t tb;
        tb = table_lookup(s_r.level);
        s_nxt = s_r;
        s_nxt.rsp_valid = 1'b0;
        // apply phase: targets follow the table except overridden ones
        if (s_r.applying) begin
            if (s_r.apply_cnt == 24'h000000) begin
                s_nxt.applying = 1'b0;
                if (!s_r.override[0]) s_nxt.target.pos_gain = tb.pos_gain;
                if (!s_r.override[1]) s_nxt.target.spd_gain = tb.spd_gain;
                if (!s_r.override[2]) s_nxt.target.spd_int  = tb.spd_int;
                if (!s_r.override[3]) s_nxt.target.trq_filt = tb.trq_filt;
            end else begin
                // finishing two cycles after the write keeps us well inside the limit
                s_nxt.apply_cnt = 24'h000000;
            end
        end
        // direct parameter writes replace the table target while tuning
        if (param_wr_i && autotune_en_i) begin
            s_nxt.override[param_sel_i] = 1'b1;
            case (param_sel_i)
                2'd0:    s_nxt.target.pos_gain = param_data_i;
                2'd1:    s_nxt.target.spd_gain = param_data_i;
                2'd2:    s_nxt.target.spd_int  = param_data_i;
                default: s_nxt.target.trq_filt = param_data_i;
            endcase
        end
        if (is_adj) begin
            s_nxt.rsp_valid = 1'b1;
            s_nxt.answer    = link.sub_command_code;
            s_nxt.rsp_addr  = link.setting_reference_address;
            s_nxt.rsp_data  = 16'h0000;
            s_nxt.status    = 16'h0000;
            s_nxt.status[ST_COMMAND_READY_FLAG] = 1'b1;
            if (link.sub_command_code == SUB_SETTING) begin
                s_nxt.rsp_data = wdata;
                if (link.setting_reference_address == ADDR_RIGIDITY) begin
                    if (wdata >= RIGIDITY_MIN && wdata <= RIGIDITY_MAX) begin
                        s_nxt.level     = wdata;
                        s_nxt.override  = 4'h0;
                        s_nxt.applying  = 1'b1;
                        s_nxt.apply_cnt = APPLY_CNT;
                    end else begin
                        s_nxt.status[ST_WARNING] = 1'b1;
                    end
                end else if (link.setting_reference_address == ADDR_INERTIA) begin
                    if (wdata <= INERTIA_MAX) s_nxt.inertia = wdata;
                    else s_nxt.status[ST_WARNING] = 1'b1;
                end else begin
                    s_nxt.status[ST_WARNING] = 1'b1;
                end
            end else if (link.sub_command_code == SUB_REFERENCE) begin
                if (link.setting_reference_address == ADDR_RIGIDITY)
                    s_nxt.rsp_data = s_r.level;
                else if (link.setting_reference_address == ADDR_INERTIA)
                    s_nxt.rsp_data = s_r.inertia;
                else
                    s_nxt.status[ST_WARNING] = 1'b1;
            end else begin
                s_nxt.status[ST_WARNING] = 1'b1;
            end
        end
    end

    // state register; power-on restarts from stored defaults
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r           <= '0;
            s_r.level     <= RIGIDITY_RESET;
            s_r.inertia   <= INERTIA_RESET;
            s_r.target    <= '{16'd40, 16'd40, 16'd2000, 16'd100};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign link.rsp_valid          = s_r.rsp_valid;
    assign link.sub_command_answer = s_r.answer;
    assign link.rsp_address        = s_r.rsp_addr;
    assign link.rsp_data           = s_r.rsp_data;
    assign link.status_word        = s_r.status;
    assign position_loop_gain_param_o  = s_r.target.pos_gain;
    assign speed_loop_gain_param_o     = s_r.target.spd_gain;
    assign speed_integral_time_param_o = s_r.target.spd_int;
    assign torque_filter_time_param_o  = s_r.target.trq_filt;
    assign inertia_ratio_param_o       = s_r.inertia;
    assign applying_o                  = s_r.applying;
endmodule // rig_drive

// ### rig_host.sv
// host end: avalon slave that runs rigidity write and verify sequences
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
module rig_host
    import rig_pkg::*;
#(
    parameter int WAIT_CYCLES = HOST_WAIT_CYCLES
)(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    rig_if.host              link,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq_o
);
    typedef enum {IDLE, SEND, WAIT_RSP, HOLD, SEND_REF, WAIT_REF} hstate_t;

    typedef struct packed {
        hstate_t      st;
        logic [2:0]   ctrl;
        logic [15:0]  addr;
        logic [15:0]  data;
        logic [15:0]  result;
        logic [1:0]   flags;
        logic [IRQ_BITS-1:0] irq_st;
        logic [IRQ_BITS-1:0] irq_en;
        logic [27:0]  wcnt;
        logic         cmd_valid;
        logic [7:0]   code;
        logic [31:0]  rdata;
        logic         ack;
        logic         irq;
    } host_state_t;

    host_state_t s_r;
    host_state_t s_nxt;

    logic rsp_ok;
    // a response is good only with ready set and no alarm or warning
    assign rsp_ok = link.status_word[ST_COMMAND_READY_FLAG] && !link.status_word[ST_ALARM]
                    && !link.status_word[ST_WARNING]
                    && link.sub_command_answer == s_r.code
                    && link.rsp_address == s_r.addr;

    always_comb begin
        logic [IRQ_BITS-1:0] ev;
        ev = '0;
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.cmd_valid = 1'b0;
        case (s_r.st)
            IDLE: begin
                if (s_r.ctrl[0]) begin
                    s_nxt.ctrl[0]   = 1'b0;
                    s_nxt.flags     = 2'b00;
                    s_nxt.code      = s_r.ctrl[1] ? SUB_SETTING : SUB_REFERENCE;
                    s_nxt.cmd_valid = 1'b1;
                    s_nxt.st        = WAIT_RSP;
                end
            end
            WAIT_RSP: begin
                if (link.rsp_valid) begin
                    if (!rsp_ok || (s_r.code == SUB_SETTING && link.rsp_data != s_r.data)) begin
                        s_nxt.flags = 2'b10;
                        ev[1] = 1'b1;
                        s_nxt.st = IDLE;
                    end else if (s_r.code == SUB_SETTING && s_r.addr == ADDR_RIGIDITY) begin
                        s_nxt.wcnt = 28'(WAIT_CYCLES);
                        s_nxt.st   = HOLD;
                    end else begin
                        s_nxt.result = link.rsp_data;
                        s_nxt.flags  = 2'b01;
                        ev[0] = 1'b1;
                        s_nxt.st = IDLE;
                    end
                end
            end
            HOLD: begin
                if (s_r.wcnt == 28'h0000000) s_nxt.st = SEND_REF;
                else s_nxt.wcnt = s_r.wcnt - 28'h0000001;
            end
            SEND_REF: begin
                s_nxt.code      = SUB_REFERENCE;
                s_nxt.cmd_valid = 1'b1;
                s_nxt.st        = WAIT_REF;
            end
            WAIT_REF: begin
                if (link.rsp_valid) begin
                    s_nxt.result = link.rsp_data;
                    if (rsp_ok && link.rsp_data == s_r.data) begin
                        s_nxt.flags = 2'b01;
                        ev[0] = 1'b1;
                    end else begin
                        s_nxt.flags = 2'b10;
                        ev[1] = 1'b1;
                    end
                    s_nxt.st = IDLE;
                end
            end
            default: s_nxt.st = IDLE;
        endcase
        // avalon slave: one wait cycle; a write lands only on the edge that sees waitrequest low
        if (avs_write && s_r.ack) begin
            case ({avs_address[4], avs_address[3:0]})
                {1'b0, REG_CTRL}:   s_nxt.ctrl = avs_writedata[2:0];
                {1'b0, REG_ADDR}:   s_nxt.addr = avs_writedata[15:0];
                {1'b0, REG_DATA}:   s_nxt.data = avs_writedata[15:0];
                {1'b1, REG_IRQ_CL}: s_nxt.irq_st = s_r.irq_st & ~avs_writedata[IRQ_BITS-1:0];
                {1'b1, REG_IRQ_EN}: s_nxt.irq_en = avs_writedata[IRQ_BITS-1:0];
                default: ;
            endcase
        end
        if ((avs_read || avs_write) && !s_r.ack) begin
            s_nxt.ack = 1'b1;
            s_nxt.rdata = 32'h00000000;
            if (avs_read) begin
                case ({avs_address[4], avs_address[3:0]})
                    {1'b0, REG_CTRL}:   s_nxt.rdata = {29'h0, s_r.st != IDLE, s_r.ctrl[1:0]};
                    {1'b0, REG_ADDR}:   s_nxt.rdata = {16'h0000, s_r.addr};
                    {1'b0, REG_DATA}:   s_nxt.rdata = {16'h0000, s_r.data};
                    {1'b0, REG_RESULT}: s_nxt.rdata = {14'h0, s_r.flags, s_r.result};
                    {1'b1, REG_IRQ_ST}: s_nxt.rdata = {30'h0, s_r.irq_st};
                    {1'b1, REG_IRQ_EN}: s_nxt.rdata = {30'h0, s_r.irq_en};
                    default: s_nxt.rdata = 32'h00000000;
                endcase
            end
        end
        // set wins over a simultaneous clear
        s_nxt.irq_st = s_nxt.irq_st | ev;
        s_nxt.irq    = |(s_nxt.irq_st & s_nxt.irq_en);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r    <= '0;
            s_r.st <= IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // link frame fields come straight from registers, except the two command bytes, which are constants
    assign link.cmd_valid                 = s_r.cmd_valid;
    assign link.cmd_byte1                 = ADJ_BYTE1;
    assign link.cmd_byte2                 = ADJ_BYTE2;
    assign link.sub_command_code          = s_r.code;
    assign link.setting_reference_address = s_r.addr;
    assign link.setting_reference_data    = s_r.data;
    assign avs_readdata                   = s_r.rdata;
    assign avs_waitrequest                = (avs_read || avs_write) && !s_r.ack;
    assign irq_o                          = s_r.irq;
endmodule // rig_host

// ### rig_if.sv
// command and response frame fields between host and drive
`timescale 1ns/1ns
interface rig_if;
    logic        cmd_valid;
    logic [7:0]  cmd_byte1;
    logic [7:0]  cmd_byte2;
    logic [7:0]  sub_command_code;
    logic [15:0] setting_reference_address;
    logic [15:0] setting_reference_data;
    logic        rsp_valid;
    logic [7:0]  sub_command_answer;
    logic [15:0] rsp_address;
    logic [15:0] rsp_data;
    logic [15:0] status_word;
    modport drive (input cmd_valid, cmd_byte1, cmd_byte2, sub_command_code,
                   setting_reference_address, setting_reference_data,
                   output rsp_valid, sub_command_answer, rsp_address, rsp_data, status_word);
    modport host  (output cmd_valid, cmd_byte1, cmd_byte2, sub_command_code,
                   setting_reference_address, setting_reference_data,
                   input rsp_valid, sub_command_answer, rsp_address, rsp_data, status_word);
endinterface

// ### rig_pkg.sv
// shared constants and types for the rigidity adjust link
package rig_pkg;
    localparam logic [7:0]  ADJ_BYTE1      = 8'h3E;   // adjusting_command selector
    localparam logic [7:0]  ADJ_BYTE2      = 8'h00;
    localparam logic [7:0]  SUB_REFERENCE  = 8'h00;
    localparam logic [7:0]  SUB_SETTING    = 8'h01;
    localparam logic [15:0] ADDR_RIGIDITY  = 16'h2003;
    localparam logic [15:0] ADDR_INERTIA   = 16'h2004;
    localparam logic [15:0] RIGIDITY_RESET = 16'h0004;
    localparam logic [15:0] RIGIDITY_MIN   = 16'h0001;
    localparam logic [15:0] RIGIDITY_MAX   = 16'h000A;
    localparam logic [15:0] INERTIA_RESET  = 16'h0000;
    localparam logic [15:0] INERTIA_MAX    = 16'h2710;
    // status word bit positions
    localparam int ST_COMMAND_READY_FLAG  = 0;
    localparam int ST_WARNING = 1;
    localparam int ST_ALARM   = 2;
    // applying a level takes this long at most (ms), counted in cycles
    localparam int  CLK_MHZ      = 100;
    localparam int  APPLY_MAX_MS = 1;
    localparam int  APPLY_CYCLES = APPLY_MAX_MS * 1000 * CLK_MHZ;
    // host avalon register offsets (word aligned byte addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0;  // bit0 start, bit1 write
    localparam logic [3:0] REG_ADDR   = 4'h4;
    localparam logic [3:0] REG_DATA   = 4'h8;
    localparam logic [3:0] REG_RESULT = 4'hC;
    localparam int         IRQ_BITS   = 2;     // bit0 done, bit1 fail
    localparam logic [3:0] REG_IRQ_ST = 4'h0;  // upper page, see addr bit 4
    localparam logic [3:0] REG_IRQ_CL = 4'h4;
    localparam logic [3:0] REG_IRQ_EN = 4'h8;
    // host wait after a rigidity write before reading back
    localparam int HOST_WAIT_MS     = 1000;
    localparam int HOST_WAIT_CYCLES = HOST_WAIT_MS * 1000 * CLK_MHZ;
    // gain table entries per level
    typedef struct packed {
        logic [15:0] pos_gain;
        logic [15:0] spd_gain;
        logic [15:0] spd_int;
        logic [15:0] trq_filt;
    } gains_t;
endpackage

// ### rig_sva.sv
// concurrent checks on the command link between host and drive
`timescale 1ns/1ns
module rig_sva
    import rig_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_byte1,
    input wire logic [7:0]  cmd_byte2,
    input wire logic [7:0]  sub_command_code,
    input wire logic [15:0] setting_reference_address,
    input wire logic [15:0] setting_reference_data,
    input wire logic        rsp_valid,
    input wire logic [7:0]  sub_command_answer,
    input wire logic [15:0] rsp_address,
    input wire logic [15:0] rsp_data,
    input wire logic [15:0] status_word
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic        adj_c;
    logic        lvl_ok_c;
    logic [15:0] level_r;
    // ------------------------------------------------------------
    // decode and level shadow
    // ------------------------------------------------------------
    assign adj_c    = cmd_valid && cmd_byte1 == ADJ_BYTE1 && cmd_byte2 == ADJ_BYTE2;
    assign lvl_ok_c = setting_reference_data >= RIGIDITY_MIN
                      && setting_reference_data <= RIGIDITY_MAX;
    // shadow of the applied level, so read-backs can be judged without the design
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_r <= RIGIDITY_RESET;
        end else if (adj_c && sub_command_code == SUB_SETTING
                     && setting_reference_address == ADDR_RIGIDITY && lvl_ok_c) begin
            level_r <= setting_reference_data;
        end
    end
    sequence s_rig_wr;
        adj_c && sub_command_code == SUB_SETTING && setting_reference_address == ADDR_RIGIDITY;
    endsequence
    sequence s_rig_ref;
        adj_c && sub_command_code == SUB_REFERENCE && setting_reference_address == ADDR_RIGIDITY;
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_adj_answers: assert property (adj_c |=> rsp_valid)
        else $error("adjusting command got no response");
    a_other_quiet: assert property (!adj_c |=> !rsp_valid)
        else $error("response without an adjusting command");
    a_answer_echo: assert property (rsp_valid |->
        sub_command_answer == $past(sub_command_code)
        && rsp_address == $past(setting_reference_address))
        else $error("answer code or address not echoed");
    a_write_echo: assert property (s_rig_wr |=> rsp_data == $past(setting_reference_data))
        else $error("written data not echoed");
    a_ready_flag: assert property (rsp_valid |-> status_word[ST_COMMAND_READY_FLAG])
        else $error("ready flag low in a response");
    a_good_clean: assert property (s_rig_wr ##0 lvl_ok_c |=>
        !status_word[ST_ALARM] && !status_word[ST_WARNING])
        else $error("alarm or warning on a good write");
    a_bad_warns: assert property (s_rig_wr ##0 !lvl_ok_c |=> status_word[ST_WARNING])
        else $error("bad level without warning");
    a_level_readback: assert property (s_rig_ref |=> rsp_data == $past(level_r))
        else $error("read-back differs from applied level");
endmodule // rig_sva

// ### test_servo_rigidity_adjust_handler.sv
// self-checking bench: host and drive ends joined across the command link
`timescale 1ns/1ns
module test_servo_rigidity_adjust_handler
    import rig_pkg::*;
;
    localparam logic [15:0] PG [10] = '{16'h000F, 16'h0014, 16'h001E, 16'h0028, 16'h003C,
                                       16'h0055, 16'h0078, 16'h00A0, 16'h00C8, 16'h00FA};
    localparam logic [15:0] IT [10] = '{16'h1770, 16'h1194, 16'h0BB8, 16'h07D0, 16'h05DC,
                                       16'h03E8, 16'h0320, 16'h0258, 16'h01F4, 16'h0190};
    localparam logic [15:0] FL [10] = '{16'h00FA, 16'h00C8, 16'h0082, 16'h0064, 16'h0046,
                                       16'h0032, 16'h001E, 16'h0014, 16'h000F, 16'h000A};
    typedef struct { logic [31:0] exp; logic [31:0] msk; } note_t;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        autotune_en_i, param_wr_i, avs_read, avs_write, app_q;
    logic        avs_waitrequest, irq_o, applying_o;
    logic [1:0]  param_sel_i, irq_en;
    logic [4:0]  avs_address;
    logic [15:0] param_data_i, pos_gain, spd_gain, spd_int, trq_filt, inertia, lv;
    logic [31:0] avs_writedata, avs_readdata, seed, rnd_v;
    gains_t      exp_g;
    note_t       nt;
    note_t       q_rd[$];
    gains_t      q_gain[$];
    int          fails, compares, cycles;
    always #5 mclk_i = ~mclk_i;
    rig_if lk();
    rig_drive rig_drive_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(lk),
        .autotune_en_i(autotune_en_i), .param_sel_i(param_sel_i), .param_wr_i(param_wr_i),
        .param_data_i(param_data_i), .position_loop_gain_param_o(pos_gain),
        .speed_loop_gain_param_o(spd_gain), .speed_integral_time_param_o(spd_int),
        .torque_filter_time_param_o(trq_filt), .inertia_ratio_param_o(inertia),
        .applying_o(applying_o));
    rig_host #(.WAIT_CYCLES(20)) rig_host_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(lk),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq_o(irq_o));
    rig_sva rig_sva_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_valid(lk.cmd_valid),
        .cmd_byte1(lk.cmd_byte1), .cmd_byte2(lk.cmd_byte2),
        .sub_command_code(lk.sub_command_code),
        .setting_reference_address(lk.setting_reference_address),
        .setting_reference_data(lk.setting_reference_data), .rsp_valid(lk.rsp_valid),
        .sub_command_answer(lk.sub_command_answer), .rsp_address(lk.rsp_address),
        .rsp_data(lk.rsp_data), .status_word(lk.status_word));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic gains_t gains(input int l);
        return '{PG[l-1], PG[l-1], IT[l-1], FL[l-1]};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one avalon transfer; reads leave their expectation for the monitor
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m, output logic [31:0] rd);
        int n;
        if (!wr) q_rd.push_back('{e, m});
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n == 50) fails++;
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk_i);  // idle edge so each request rises fresh
    endtask
    // one host sequence: load, start, poll for an event, check result and irq
    task automatic op(input logic [31:0] ctl, input logic [15:0] adr, input logic [15:0] dat,
                      input logic [31:0] e_res, input logic [31:0] m_res, input logic [1:0] e_st);
        logic [31:0] r;
        int n;
        av(1'b1, 5'h04, {16'h0000, adr}, 32'h0, 32'h0, r);
        av(1'b1, 5'h08, {16'h0000, dat}, 32'h0, 32'h0, r);
        av(1'b1, 5'h00, ctl, 32'h0, 32'h0, r);
        r = 32'h0;
        n = 0;
        while (r[1:0] == 2'h0 && n < 300) begin
            av(1'b0, 5'h10, 32'h0, 32'h0, 32'h0, r);
            n++;
        end
        check({63'h0, irq_o}, {63'h0, |(e_st & irq_en)}, "irq level");
        av(1'b0, 5'h0C, 32'h0, e_res, m_res, r);
        av(1'b0, 5'h10, 32'h0, {30'h0, e_st}, 32'h3, r);
        av(1'b1, 5'h14, 32'h3, 32'h0, 32'h0, r);
        av(1'b0, 5'h10, 32'h0, 32'h0, 32'h3, r);
        check({63'h0, irq_o}, 64'h0, "irq after clear");
    endtask
    // ------------------------------------------------------------
    // monitor: oldest note against each result that appears
    // ------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (avs_read && avs_waitrequest === 1'b0 && q_rd.size() > 0) begin
            nt = q_rd.pop_front();
            if (nt.msk != 32'h0) check(avs_readdata & nt.msk, nt.exp & nt.msk, "readdata");
        end
        if (app_q === 1'b1 && applying_o === 1'b0 && q_gain.size() > 0) begin
            check({pos_gain, spd_gain, spd_int, trq_filt}, q_gain.pop_front(), "gains");
        end
        app_q <= applying_o;
        cycles++;
        if (cycles == 60000) begin
            fails++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        seed = 32'h0596;
        {autotune_en_i, param_wr_i, avs_read, avs_write} = 4'h0;
        {param_sel_i, irq_en, avs_address, param_data_i, avs_writedata} = 57'h0;
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        check({pos_gain, spd_gain, spd_int, trq_filt}, gains(4), "reset gains");
        check({48'h0, inertia}, {48'h0, INERTIA_RESET}, "reset inertia");
        irq_en = 2'h3;
        av(1'b1, 5'h18, 32'h3, 32'h0, 32'h0, r);
        op(32'h1, ADDR_RIGIDITY, 16'h0, {16'h0001, RIGIDITY_RESET}, 32'h3FFFF, 2'h1);
        op(32'h1, ADDR_INERTIA, 16'h0, {16'h0001, INERTIA_RESET}, 32'h3FFFF, 2'h1);
        // every table level; each write is read back by the host before done
        for (int l = 1; l <= 10; l++) begin
            q_gain.push_back(gains(l));
            op(32'h3, ADDR_RIGIDITY, l[15:0], {16'h0001, l[15:0]}, 32'h3FFFF, 2'h1);
        end
        // levels 0 and far above ten are refused
        for (int k = 0; k < 2; k++) begin
            rnd_v = rnd();
            lv = (k == 0) ? 16'h0000 : (rnd_v[15:0] | 16'h0100);
            op(32'h3, ADDR_RIGIDITY, lv, 32'h20000, 32'h30000, 2'h2);
        end
        op(32'h1, ADDR_RIGIDITY, 16'h0, {16'h0001, 16'h000A}, 32'h3FFFF, 2'h1);
        op(32'h3, ADDR_INERTIA, INERTIA_MAX, 32'h10000, 32'h30000, 2'h1);
        op(32'h3, ADDR_INERTIA, INERTIA_MAX + 16'h1, 32'h20000, 32'h30000, 2'h2);
        check({48'h0, inertia}, {48'h0, INERTIA_MAX}, "inertia");
        // masked: status still records the event, the line stays low
        irq_en = 2'h0;
        av(1'b1, 5'h18, 32'h0, 32'h0, 32'h0, r);
        op(32'h1, ADDR_RIGIDITY, 16'h0, {16'h0001, 16'h000A}, 32'h3FFFF, 2'h1);
        av(1'b0, 5'h1C, 32'h0, 32'h0, 32'hFFFFFFFF, r);
        // direct parameter write while tuning replaces that target until the next level write
        rnd_v = rnd();
        autotune_en_i <= 1'b1;
        param_sel_i   <= rnd_v[17:16];
        param_data_i  <= rnd_v[15:0];
        param_wr_i    <= 1'b1;
        @(posedge mclk_i);
        param_wr_i <= 1'b0;
        @(posedge mclk_i);
        exp_g = gains(10);
        exp_g[63 - 16 * rnd_v[17:16] -: 16] = rnd_v[15:0];
        check({pos_gain, spd_gain, spd_int, trq_filt}, exp_g, "override");
        q_gain.push_back(gains(7));
        op(32'h3, ADDR_RIGIDITY, 16'h0007, {16'h0001, 16'h0007}, 32'h3FFFF, 2'h1);
        autotune_en_i <= 1'b0;
        // power cycle drops unsaved tuning state
        rst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        check({pos_gain, spd_gain, spd_int, trq_filt}, gains(4), "restart gains");
        irq_en = 2'h3;
        av(1'b1, 5'h18, 32'h3, 32'h0, 32'h0, r);
        op(32'h1, ADDR_RIGIDITY, 16'h0, {16'h0001, RIGIDITY_RESET}, 32'h3FFFF, 2'h1);
        repeat (4) @(posedge mclk_i);
        check(64'(q_rd.size() + q_gain.size()), 64'h0, "pending notes");
        end_of_test();
    end
endmodule // test_servo_rigidity_adjust_handler
